// >>> hw/sacs_pkg.sv
// constants, state codes and register map of the conversion sequencer
// How it works
// - a full conversion takes 9.5 bit periods from start to result load
// - bit period is 2, 8 or 32 oscillator periods, or the rc clock
// - after completion wait 2 bit periods with holding capacitor disconnected
// - clearing go/done during a conversion aborts it at once
// - an aborted conversion leaves the result register untouched
// - after an abort wait 2 bit periods then acquire on selected channel
// - port data reads zero on every pin configured as analog input
// - conversion ignores pin direction; an output pin converts its own level
// - a digital-input pin selected as channel is still converted normally
// - clock may switch among oscillator sources mid-conversion, never to/from rc
// - sleep conversion needs rc clock; rc start is delayed one instruction cycle
// - sleep completion with irq enabled clears go, loads result, wakes device
// - sleep completion with irq disabled powers module down, converter on stays set
// - sleep with non-rc clock aborts, powers down, converter on stays set
// - completion loads result, clears go/done and sets the done flag
// - go/done set while acquiring starts a conversion and reads one meanwhile
// - control holds clock select 7:6, channel 5:3, go 2, on 0
package sacs_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_RES = 8'h04;
    localparam logic [7:0] ADR_PCFG = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0c;
    localparam logic [7:0] ADR_PORT = 8'h10;
    localparam int CTRL_SEL_LSB = 6;
    localparam int CTRL_CHAN_LSB = 3;
    localparam int CTRL_GO_BIT = 2;
    localparam int CTRL_ON_BIT = 0;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_IRQEN_BIT = 1;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [2:0] PCFG_RST = 3'h0;
    localparam logic [7:0] RES_RST = 8'h00;
    // ---------------------------------------------------------------
    // clock selection and timing: dividers and rc start delay in clocks, phase ends in half bit periods
    // ---------------------------------------------------------------
    localparam logic [1:0] SEL_RC = 2'h3;
    localparam logic [4:0] HALF_DIV_2 = 5'h01;
    localparam logic [4:0] HALF_DIV_8 = 5'h04;
    localparam logic [4:0] HALF_DIV_32 = 5'h10;
    localparam logic [4:0] CONV_LAST = 5'h12;
    localparam logic [4:0] DEC_FIRST = 5'h03;
    localparam logic [4:0] DEC_LAST = 5'h11;
    localparam logic [4:0] REC_LAST = 5'h03;
    localparam logic [2:0] INSTR_LAST = 3'h3;
    typedef enum logic [4:0] {
        ST_OFF = 5'b00001,
        ST_ACQ = 5'b00010,
        ST_DLY = 5'b00100,
        ST_CNV = 5'b01000,
        ST_REC = 5'b10000
    } sacs_state_t;
endpackage

// >>> hw/sacs_seq_if.sv
// signals shared by the sequencer, its prescaler and its approximation register
`timescale 1ns/1ns
interface sacs_seq_if;
    logic [1:0] sel;
    logic run;
    logic restart;
    logic half;
    logic decide;
    logic cmp;
    logic [7:0] trial;
    logic [7:0] code;
    modport ctl(output sel, run, restart, decide, cmp, input half, trial, code);
    modport pre(input sel, run, restart, output half);
    modport sar(input run, decide, cmp, output trial, code);
endinterface

// >>> hw/sacs_prescaler.sv
// half bit-period strobe generator for the four clock sources
`timescale 1ns/1ns
module sacs_prescaler
    import sacs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rc_clk_i,
    sacs_seq_if.pre seq
);
    import sacs_pkg::*;
    logic [4:0] cnt_r;
    logic rc_meta_r;
    logic rc_sync_r;
    logic rc_last_r;
    logic [4:0] div;
    logic osc_hit;
    logic rc_edge;

    function automatic logic [4:0] half_div(input logic [1:0] sel);
        case (sel)
            2'h0: half_div = HALF_DIV_2;
            2'h1: half_div = HALF_DIV_8;
            default: half_div = HALF_DIV_32;
        endcase
    endfunction

    assign div = half_div(seq.sel);
    // >= so that a switch to a shorter period mid-count still strobes
    assign osc_hit = cnt_r >= div - 5'h01;
    assign rc_edge = rc_sync_r ^ rc_last_r;
    assign seq.half = seq.run && ((seq.sel == SEL_RC) ? rc_edge : osc_hit);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !seq.run || seq.restart || osc_hit)
            cnt_r <= 5'h00;
        else
            cnt_r <= cnt_r + 5'h01;
    end

    // rc clock is asynchronous: two flops, edge seen only past the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rc_meta_r <= 1'b0;
            rc_sync_r <= 1'b0;
            rc_last_r <= 1'b0;
        end
        else
        begin
            rc_meta_r <= rc_clk_i;
            rc_sync_r <= rc_meta_r;
            rc_last_r <= rc_sync_r;
        end
    end
endmodule // sacs_prescaler

// >>> hw/sacs_sar.sv
// successive-approximation register: trial code and kept bits
`timescale 1ns/1ns
module sacs_sar
    import sacs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    sacs_seq_if.sar seq
);
    import sacs_pkg::*;
    logic [7:0] bit_r;
    logic [7:0] code_r;
    logic [7:0] trial_r;
    logic [7:0] code_nxt;

    // comparator high means the input is at or above the trial level
    assign code_nxt = seq.cmp ? (code_r | bit_r) : code_r;
    assign seq.trial = trial_r;
    assign seq.code = code_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !seq.run)
        begin
            bit_r <= 8'h80;
            code_r <= 8'h00;
            trial_r <= 8'h80;
        end
        else if (seq.decide)
        begin
            bit_r <= bit_r >> 1;
            code_r <= code_nxt;
            trial_r <= code_nxt | (bit_r >> 1);
        end
    end
endmodule // sacs_sar

// >>> hw/sacs_top.sv
// conversion sequencer with its wishbone register file
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ns
module sacs_top
    import sacs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rc_clk_i,
    input wire logic sleep_i,
    input wire logic cmp_i,
    input wire logic [7:0] pin_level_i,
    output logic sample_o,
    output logic [2:0] channel_o,
    output logic [7:0] trial_o,
    output logic analog_on_o,
    output logic wake_o
);
    import sacs_pkg::*;

    // ---------------------------------------------------------------
    // state and registers
    // ---------------------------------------------------------------
    sacs_state_t st_r;
    sacs_state_t st_nxt;
    logic [1:0] sel_r;
    logic [2:0] chan_r;
    logic on_r;
    logic go_r;
    logic [7:0] res_r;
    logic [2:0] pcfg_r;
    logic done_r;
    logic irqen_r;
    logic pdn_r;
    logic wake_r;
    logic [4:0] half_cnt_r;
    logic [2:0] dly_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic sample_r;
    logic [2:0] chan_out_r;
    logic [7:0] trial_r;
    logic aon_r;

    sacs_seq_if seq();

    sacs_prescaler u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rc_clk_i(rc_clk_i),
        .seq(seq)
    );

    sacs_sar u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .seq(seq)
    );

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic bus_hit;
    logic wr;
    logic rd;
    logic wr_ctrl;
    logic wr_res;
    logic wr_pcfg;
    logic wr_stat;
    logic [1:0] new_sel;
    logic sel_ok;
    logic busy;
    logic start;
    logic conv_last;
    logic conv_done;
    logic sw_abort;
    logic sleep_abort;
    logic abort;
    logic rec_done;
    logic on_nxt;
    logic pdn_nxt;
    logic [7:0] analog_mask;
    logic [7:0] rd_byte;

    // pins that the port configuration makes analog (vref pin included)
    function automatic logic [7:0] analog_pins(input logic [2:0] cfg);
        case (cfg)
            3'h0: analog_pins = 8'hff;
            3'h1: analog_pins = 8'hff;
            3'h2: analog_pins = 8'h1f;
            3'h3: analog_pins = 8'h3f;
            3'h4: analog_pins = 8'h0b;
            3'h5: analog_pins = 8'h0b;
            default: analog_pins = 8'h00;
        endcase
    endfunction

    assign bus_hit = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = bus_hit && wb_we_i && wb_sel_i[0];
    assign rd = bus_hit && !wb_we_i;
    assign wr_ctrl = wr && (wb_adr_i == ADR_CTRL);
    assign wr_res = wr && (wb_adr_i == ADR_RES);
    assign wr_pcfg = wr && (wb_adr_i == ADR_PCFG);
    assign wr_stat = wr && (wb_adr_i == ADR_STAT);
    assign new_sel = wb_dat_i[CTRL_SEL_LSB+1:CTRL_SEL_LSB];
    assign analog_mask = analog_pins(pcfg_r);

    assign rd_byte =
        (wb_adr_i == ADR_CTRL) ? {sel_r, chan_r, go_r, 1'b0, on_r} :
        (wb_adr_i == ADR_RES) ? res_r :
        (wb_adr_i == ADR_PCFG) ? {5'h00, pcfg_r} :
        (wb_adr_i == ADR_STAT) ? {5'h00, pdn_r, irqen_r, done_r} :
        (wb_adr_i == ADR_PORT) ? (pin_level_i & ~analog_mask) :
        8'h00;

    // ---------------------------------------------------------------
    // sequencing decisions
    // ---------------------------------------------------------------
    assign busy = (st_r == ST_DLY) || (st_r == ST_CNV);
    // a running conversion may not cross between rc and oscillator clocks
    assign sel_ok = !busy || ((new_sel == SEL_RC) == (sel_r == SEL_RC));
    assign start = (st_r == ST_ACQ) && wr_ctrl && wb_dat_i[CTRL_GO_BIT]
        && wb_dat_i[CTRL_ON_BIT];
    assign conv_last = (st_r == ST_CNV) && seq.half && (half_cnt_r == CONV_LAST);
    assign sw_abort = busy && wr_ctrl && !wb_dat_i[CTRL_GO_BIT];
    assign sleep_abort = busy && sleep_i && (sel_r != SEL_RC);
    assign abort = sw_abort || sleep_abort;
    assign conv_done = conv_last && !abort;
    assign rec_done = (st_r == ST_REC) && seq.half && (half_cnt_r == REC_LAST);
    assign on_nxt = wr_ctrl ? wb_dat_i[CTRL_ON_BIT] : on_r;
    // powered down stays until the device leaves sleep
    assign pdn_nxt = sleep_abort || (conv_done && sleep_i && !irqen_r)
        || (pdn_r && sleep_i);

    assign seq.sel = sel_r;
    assign seq.run = (st_r == ST_CNV) || (st_r == ST_REC);
    assign seq.restart = st_nxt != st_r;
    assign seq.cmp = cmp_i;
    assign seq.decide = (st_r == ST_CNV) && seq.half && half_cnt_r[0]
        && (half_cnt_r >= DEC_FIRST) && (half_cnt_r <= DEC_LAST);

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_OFF:
                if (on_r && !pdn_r)
                    st_nxt = ST_ACQ;
            ST_ACQ:
                if (start)
                    st_nxt = (new_sel == SEL_RC) ? ST_DLY : ST_CNV;
            ST_DLY:
                if (abort)
                    st_nxt = ST_REC;
                else if (dly_r == INSTR_LAST)
                    st_nxt = ST_CNV;
            ST_CNV:
                if (abort || conv_last)
                    st_nxt = ST_REC;
            ST_REC:
                if (rec_done)
                    st_nxt = ST_ACQ;
            default:
                st_nxt = ST_OFF;
        endcase
        if (!on_nxt || pdn_nxt)
            st_nxt = ST_OFF;
    end

    // ---------------------------------------------------------------
    // clocked state
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= ST_OFF;
            half_cnt_r <= 5'h00;
            dly_r <= 3'h0;
            go_r <= 1'b0;
            pdn_r <= 1'b0;
            wake_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            half_cnt_r <= seq.restart ? 5'h00 : half_cnt_r + {4'h0, seq.half};
            dly_r <= (st_r == ST_DLY) ? dly_r + 3'h1 : 3'h0;
            go_r <= (st_nxt == ST_DLY) || (st_nxt == ST_CNV);
            pdn_r <= pdn_nxt;
            wake_r <= (conv_done && sleep_i && irqen_r) || (wake_r && sleep_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sel_r <= SEL_RST;
            chan_r <= CHAN_RST;
            on_r <= 1'b0;
            pcfg_r <= PCFG_RST;
            irqen_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && sel_ok)
                sel_r <= new_sel;
            if (wr_ctrl)
                chan_r <= wb_dat_i[CTRL_CHAN_LSB+2:CTRL_CHAN_LSB];
            on_r <= on_nxt;
            if (wr_pcfg)
                pcfg_r <= wb_dat_i[2:0];
            if (wr_stat)
                irqen_r <= wb_dat_i[STAT_IRQEN_BIT];
        end
    end

    // completion beats a same-cycle software write or flag clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            res_r <= RES_RST;
            done_r <= 1'b0;
        end
        else
        begin
            if (conv_done)
                res_r <= seq.code;
            else if (wr_res)
                res_r <= wb_dat_i[7:0];
            done_r <= conv_done || (done_r && !(wr_stat && wb_dat_i[STAT_DONE_BIT]));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            sample_r <= 1'b0;
            chan_out_r <= CHAN_RST;
            trial_r <= 8'h00;
            aon_r <= 1'b0;
        end
        else
        begin
            ack_r <= bus_hit;
            dat_r <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            sample_r <= st_nxt == ST_ACQ;
            // the selected pin is routed whatever its direction
            chan_out_r <= chan_r;
            trial_r <= seq.trial;
            aon_r <= st_nxt != ST_OFF;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign sample_o = sample_r;
    assign channel_o = chan_out_r;
    assign trial_o = trial_r;
    assign analog_on_o = aon_r;
    assign wake_o = wake_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_go_needs_on: assert property (go_r |-> on_r)
        else $error("go set while converter off");
    a_done_load: assert property (conv_done && !sleep_i && !wr_ctrl
        |=> st_r == ST_REC && done_r && !go_r && res_r == $past(seq.code))
        else $error("completion did not load result");
    a_abort_keep: assert property (sw_abort && wb_dat_i[CTRL_ON_BIT]
        |=> st_r == ST_REC && res_r == $past(res_r) && !go_r)
        else $error("abort changed result");
    a_rec_no_sample: assert property (st_r == ST_REC |-> !sample_o)
        else $error("capacitor connected during recovery");
    a_rec_to_acq: assert property (rec_done && on_nxt && !pdn_nxt |=> st_r == ST_ACQ)
        else $error("no acquisition after recovery");
    a_rc_lock: assert property (busy && $past(busy)
        |-> (sel_r == SEL_RC) == ($past(sel_r) == SEL_RC))
        else $error("clock crossed rc boundary mid-conversion");
    a_sleep_abort: assert property (sleep_abort |=> st_r == ST_OFF && on_r && !analog_on_o)
        else $error("sleep did not power down");
    a_rc_delay: assert property (st_r == ST_CNV && $past(st_r) == ST_DLY
        |-> $past(st_r, 4) == ST_DLY)
        else $error("rc start delay too short");
    a_port_analog: assert property (ack_r && $past(rd) && $past(wb_adr_i) == ADR_PORT
        |-> (wb_dat_o[7:0] & analog_mask) == 8'h00)
        else $error("analog pin read nonzero");
    a_conv_span: assert property (conv_done && sel_r == 2'h0
        && $past(sel_r, 18) == 2'h0 |-> $past(st_r, 18) == ST_CNV && $past(st_r, 19) != ST_CNV)
        else $error("conversion length wrong");

    c_complete: cover property (conv_done);
    c_abort: cover property (sw_abort);
    c_wake: cover property ($rose(wake_o));
    c_switch: cover property (busy && wr_ctrl && sel_ok && new_sel != sel_r);
endmodule // sacs_top

// >>> testbench/sacs_analog_model.sv
// behavioural sample-and-hold and comparator facing the conversion sequencer
`timescale 1ns/1ns
module sacs_analog_model (
    input wire logic clk_i,
    input wire logic sample_i,
    input wire logic [2:0] channel_i,
    input wire logic [7:0] trial_i,
    input wire logic analog_on_i,
    input wire logic [63:0] levels_i,
    output logic cmp_o
);
    logic [7:0] held_r = 8'h00;
    logic junk_r = 1'b0;
    // pin direction plays no part: whatever level the pin carries is held
    always @(posedge clk_i)
    begin
        junk_r <= ~junk_r;
        if (sample_i && analog_on_i)
            held_r <= levels_i[channel_i*8 +: 8];
    end
    // powered down: the comparator output means nothing, so it wanders
    assign cmp_o = analog_on_i ? (held_r >= trial_i) : junk_r;
endmodule // sacs_analog_model

// >>> testbench/tb_sar_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer and its register file
`timescale 1ns/1ns
module tb_sar_adc_conversion_sequencer;
    import sacs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic rc_clk_i = 1'b0;
    logic sleep_i = 1'b0;
    logic cmp_i;
    logic [7:0] pin_level_i = 8'h00;
    logic sample_o, analog_on_o, wake_o;
    logic [2:0] channel_o;
    logic [7:0] trial_o;
    logic [63:0] levels = 64'h0;
    logic [63:0] rq[$];
    int wq[$];
    logic [63:0] note;
    logic [31:0] rdata;
    logic [7:0] lvl;
    int err_count = 0;
    int compares = 0;
    int low_cnt = 0;
    int exp_w;
    int n;
    int unsigned seed_v;
    logic [7:0] u_adr[5] = '{ADR_CTRL, ADR_RES, ADR_PCFG, ADR_STAT, 8'h20};

    always #50 clk_i = ~clk_i;
    always #350 rc_clk_i = ~rc_clk_i;

    sacs_top u_sacs_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rc_clk_i(rc_clk_i), .sleep_i(sleep_i), .cmp_i(cmp_i), .pin_level_i(pin_level_i),
        .sample_o(sample_o), .channel_o(channel_o), .trial_o(trial_o),
        .analog_on_o(analog_on_o), .wake_o(wake_o));
    sacs_analog_model u_sacs_analog_model (.clk_i(clk_i), .sample_i(sample_o),
        .channel_i(channel_o), .trial_i(trial_o), .analog_on_i(analog_on_o),
        .levels_i(levels), .cmp_o(cmp_i));

    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    task automatic bad(input string msg);
        err_count++;
        $display("BAD %0t %s", $time, msg);
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= dat;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50)
            bad("no acknowledge");
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        wb(1'b1, adr, {24'h0, dat});
    endtask

    // a zero mask marks a read whose data is only used by the caller
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        rq.push_back({msk, exp});
        wb(1'b0, adr, 32'h0);
    endtask

    // 0: capacitor connected, 1: wake raised, 2: analog powered down
    task automatic wait_sig(input int k);
        int c;
        c = 0;
        while (c < 2000 && !(k == 0 ? sample_o === 1'b1 :
               k == 1 ? wake_o === 1'b1 : analog_on_o === 1'b0))
        begin
            @(posedge clk_i);
            c++;
        end
        if (c >= 2000)
            bad("wait timed out");
    endtask

    task automatic wait_done();
        int c;
        c = 0;
        do
        begin
            rd(ADR_CTRL, 32'h0, 32'h0);
            c++;
        end
        while (rdata[CTRL_GO_BIT] !== 1'b0 && c < 400);
        if (c >= 400)
            bad("go bit stuck");
    endtask

    function automatic logic [7:0] amask(input int p);
        case (p)
            0, 1: return 8'hff;
            2: return 8'h1f;
            3: return 8'h3f;
            4, 5: return 8'h0b;
            default: return 8'h00;
        endcase
    endfunction

    // go in ctl with a non-rc clock asks for the busy-time check; the first write never carries go
    task automatic start(input logic [7:0] ctl);
        wr(ADR_CTRL, ctl & 8'hfb);
        wait_sig(0);
        repeat (30) @(posedge clk_i); // acquisition before go
        if (ctl[7:6] != SEL_RC && ctl[2])
            wq.push_back(ctl[7:6] == 2'h0 ? 23 : ctl[7:6] == 2'h1 ? 92 : 368);
        wr(ADR_CTRL, ctl | 8'h04);
    endtask

    task automatic finish_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // monitors: read data and capacitor-off time against the notes
    // ---------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o === 1'b1)
        begin
            if (rq.size() == 0)
                bad("read without note");
            else
            begin
                note = rq.pop_front();
                if (note[63:32] != 32'h0)
                begin
                    compares++;
                    if ((wb_dat_o & note[63:32]) !== note[31:0])
                        bad($sformatf("read %h want %h", wb_dat_o, note[31:0]));
                end
            end
        end
        if (sample_o === 1'b0)
            low_cnt++;
        else
        begin
            if (low_cnt != 0 && wq.size() != 0)
            begin
                exp_w = wq.pop_front();
                compares++;
                if (low_cnt != exp_w)
                    bad($sformatf("busy %0d clocks want %0d", low_cnt, exp_w));
            end
            low_cnt = 0;
        end
    end

    initial
    begin
        #3_000_000;
        bad("watchdog");
        finish_test();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        seed_v = $urandom(32'h49c6);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (u_adr[i])
            rd(u_adr[i], 32'h0, 32'hff);
        for (int p = 0; p < 8; p++)
        begin
            pin_level_i <= 8'($urandom());
            wr(ADR_PCFG, 8'(p));
            rd(ADR_PORT, {24'h0, pin_level_i & ~amask(p)}, 32'hff);
        end
        // all pins digital now: conversions must still see the analog level
        for (int s = 0; s < 3; s++)
        begin
            lvl = 8'($urandom());
            n = $urandom_range(7);
            levels[n*8 +: 8] <= lvl;
            start({2'(s), 3'(n), 3'b101});
            rd(ADR_CTRL, {24'h0, 2'(s), 3'(n), 3'b101}, 32'hff);
            wait_done();
            rd(ADR_RES, {24'h0, lvl}, 32'hff);
            rd(ADR_STAT, 32'h1, 32'h1);
            wr(ADR_STAT, 8'h01);
            wait_sig(0);
        end
        wr(ADR_RES, 8'h5a);
        start(8'h81);
        repeat (40) @(posedge clk_i);
        wr(ADR_CTRL, 8'h81);
        n = 0;
        while (sample_o !== 1'b1 && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        compares++;
        if (n < 60 || n > 68)
            bad($sformatf("reacquire after %0d clocks", n));
        rd(ADR_CTRL, 32'h81, 32'hff);
        rd(ADR_RES, 32'h5a, 32'hff);
        start(8'h81); // 3.2 us bit period
        repeat (50) @(posedge clk_i); // a few full-length half bits first
        wr(ADR_CTRL, 8'hc5);
        rd(ADR_CTRL, 32'h85, 32'hff);
        wr(ADR_CTRL, 8'h05);
        rd(ADR_CTRL, 32'h00, 32'hc0);
        wait_done();
        wait_sig(0);
        start(8'h81);
        repeat (20) @(posedge clk_i);
        sleep_i <= 1'b1;
        wait_sig(2);
        rd(ADR_CTRL, 32'h81, 32'hff);
        rd(ADR_STAT, 32'h4, 32'h4);
        sleep_i <= 1'b0;
        wait_sig(0);
        rd(ADR_STAT, 32'h0, 32'h4);
        for (int ie = 1; ie >= 0; ie--)
        begin
            lvl = 8'($urandom());
            levels[15:8] <= lvl;
            wr(ADR_STAT, {6'h0, 1'(ie), 1'b1});
            start(8'hc9); // go comes before sleep
            sleep_i <= 1'b1;
            wait_sig(ie != 0 ? 1 : 2);
            rd(ADR_CTRL, 32'hc9, 32'hff);
            rd(ADR_STAT, {29'h0, 1'(1 - ie), 2'h0}, 32'h4);
            rd(ADR_RES, {24'h0, lvl}, 32'hff);
            sleep_i <= 1'b0;
            wait_sig(0);
        end
        finish_test();
    end
endmodule // tb_sar_adc_conversion_sequencer
